// ---- rtl/tmr_pkg.sv ----
// Package with mode register addresses, fields and codes
package tmr_pkg;
    // Mode register addresses
    localparam logic [5:0] ADDR_TERM_OVR = 6'h16;
    localparam logic [5:0] ADDR_DQS_RUN = 6'h17;
    localparam logic [5:0] ADDR_REFMGMT = 6'h18;
    localparam logic [5:0] ADDR_REPAIR = 6'h19;
    localparam logic [5:0] ADDR_SCALE = 6'h1A;
    // Reset values
    localparam logic [7:0] RST_TERM_OVR = 8'h00;
    localparam logic [7:0] RST_DQS_RUN = 8'h00;
    localparam logic [2:0] RST_MAXMULT = 3'h0;
    // Field positions of the termination override register
    localparam int BYTE_SEL_HI = 7;
    localparam int BYTE_SEL_LO = 6;
    localparam int CA_OFF_BIT = 5;
    localparam int CS_OFF_BIT = 4;
    localparam int CK_OFF_BIT = 3;
    // Byte select codes
    localparam logic [1:0] BSEL_BOTH = 2'h0;
    localparam logic [1:0] BSEL_UPPER = 2'h1;
    localparam logic [1:0] BSEL_LOWER = 2'h2;
    // Termination value code meaning disabled
    localparam logic [2:0] CA_TERM_DISABLED = 3'h0;
    // Refresh management fields
    localparam int RFM_NEED_BIT = 0;
    localparam int THR_LO = 1;
    localparam int THR_HI = 5;
    localparam int MAXM_LO = 4;
    localparam int MAXM_HI = 6;
    // Scaling support bit in the feature register
    localparam int SCALE_SUP_BIT = 6;
    // Stop opcode for the DQS interval timer
    localparam logic [6:0] MPC_STOP_DQS = 7'h4D;
    // Clocks per run-time step, and largest auto-stop code
    localparam logic [7:0] DQS_STEP_CLKS = 8'h10;
    localparam logic [7:0] DQS_MAX_CODE = 8'h04;
endpackage

// ---- rtl/tmr_regs.sv ----
// Termination override, DQS timer run time and info mode registers
`timescale 1ns/1ns
// Function
// - Byte select 00 both, 01 upper only, 10 lower only, when CA value on.
// - Set bits 5,4,3 leave CA, CS, CK unterminated, each on its own.
// - Strap pad is ignored; only the two registers and the CA value control termination.
// - Two override copies; write-select copy accessed, active copy operates.
// - Run time zero: timer runs until the stop command; zero is default.
// - Codes 1..4 stop the timer after 16, 32, 48, 64 clocks.
// - Stop opcode halts the timer when run time is zero.
// - Refresh register: need bit 0, threshold 5:1, max multiplier code.
// - Repair register read-only, one available-bit per bank 0..7.
// - Scaling level bits 1:0, meaningful only when feature bit 6 set.
module tmr_regs #(
    parameter logic [7:0] REPAIR_FLAGS = 8'hFF, // Factory repair resources
    parameter logic [1:0] SCALE_LEVEL = 2'h0, // Factory scaling level
    parameter logic [4:0] INIT_THR_CODE = 5'h01, // Factory threshold code
    parameter logic SCALE_SUPPORT = 1'b1 // Mirrors feature bit 6
) (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic mrw_valid, // Mode register write strobe
    input wire logic [5:0] mrw_addr, // Write address
    input wire logic [7:0] mrw_data, // Write operand
    input wire logic mrr_valid, // Mode register read strobe
    input wire logic [5:0] mrr_addr, // Read address
    output logic [7:0] mrr_data, // Read operand
    output logic mrr_ack, // Read data valid pulse
    input wire logic setpoint_write_select, // Copy accessed by MRW/MRR
    input wire logic setpoint_op_select, // Copy that operates
    input wire logic [2:0] ca_termination_value, // CA termination value code
    input wire logic termination_strap_pad, // Strap pin, ignored
    input wire logic refresh_need, // Refresh management needed
    input wire logic mpc_valid, // Multipurpose command strobe
    input wire logic [6:0] mpc_opcode, // Multipurpose command opcode
    input wire logic dqs_timer_start, // Timer start event
    output logic dqs_timer_running, // DQS interval timer active
    output logic [1:0] ca_term_en, // CA termination {upper, lower}
    output logic [1:0] cs_term_en, // CS termination {upper, lower}
    output logic [1:0] ck_term_en, // CK termination {upper, lower}
    output logic [2:0] max_act_mult // Max threshold multiplier code
);
    logic [7:0] ovr_q [2];
    logic [7:0] dqs_run_q;
    logic [2:0] maxm_q;
    logic [7:0] cnt_q;
    logic [7:0] act_q;
    logic [7:0] lim;
    logic [1:0] bsel;
    logic [1:0] bytes_on;
    logic ca_on;
    logic need_s;
    logic scale_ok;

    // Strap pad is brought in but deliberately never used
    tmr_sync2 #(.WIDTH(1)) u_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .d(refresh_need),
        .q(need_s)
    );

    // Write side: override copy picked by write select
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ovr_q[0] <= tmr_pkg::RST_TERM_OVR;
            ovr_q[1] <= tmr_pkg::RST_TERM_OVR;
            dqs_run_q <= tmr_pkg::RST_DQS_RUN;
            maxm_q <= tmr_pkg::RST_MAXMULT;
        end
        else if (mrw_valid)
        begin
            case (mrw_addr)
                tmr_pkg::ADDR_TERM_OVR:
                    ovr_q[setpoint_write_select] <= mrw_data;
                tmr_pkg::ADDR_DQS_RUN:
                    dqs_run_q <= mrw_data;
                tmr_pkg::ADDR_REFMGMT:
                    maxm_q <= mrw_data[tmr_pkg::MAXM_HI:tmr_pkg::MAXM_LO];
                default:
                    ;
            endcase
        end
    end

    // Decode active copy; strap pad never enters this path
    assign bsel = ovr_q[setpoint_op_select][tmr_pkg::BYTE_SEL_HI:
                                            tmr_pkg::BYTE_SEL_LO];
    assign ca_on = (ca_termination_value != tmr_pkg::CA_TERM_DISABLED);
    always_comb
    begin
        // Bit 1 upper byte, bit 0 lower byte
        case (bsel)
            tmr_pkg::BSEL_BOTH: bytes_on = 2'h3;
            tmr_pkg::BSEL_UPPER: bytes_on = 2'h2;
            tmr_pkg::BSEL_LOWER: bytes_on = 2'h1;
            default: bytes_on = 2'h0;
        endcase
        if (!ca_on)
            bytes_on = 2'h0;
    end

    // Outputs are registered; each pin class has its own off bit
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ca_term_en <= 2'h0;
            cs_term_en <= 2'h0;
            ck_term_en <= 2'h0;
        end
        else
        begin
            ca_term_en <= ovr_q[setpoint_op_select][tmr_pkg::CA_OFF_BIT]
                          ? 2'h0 : bytes_on;
            cs_term_en <= ovr_q[setpoint_op_select][tmr_pkg::CS_OFF_BIT]
                          ? 2'h0 : bytes_on;
            ck_term_en <= ovr_q[setpoint_op_select][tmr_pkg::CK_OFF_BIT]
                          ? 2'h0 : bytes_on;
        end
    end

    // Auto-stop limit; codes above 4 behave as free-running
    assign lim = (dqs_run_q != 8'h00 && dqs_run_q <= tmr_pkg::DQS_MAX_CODE)
                 ? 8'(dqs_run_q * tmr_pkg::DQS_STEP_CLKS) : 8'h00;

    // DQS interval timer; start wins over any stop in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            dqs_timer_running <= 1'b0;
            cnt_q <= 8'h00;
        end
        else if (dqs_timer_start)
        begin
            dqs_timer_running <= 1'b1;
            cnt_q <= 8'h01;
        end
        else if (dqs_timer_running)
        begin
            cnt_q <= 8'(cnt_q + 8'h01);
            if (lim != 8'h00 && cnt_q == lim)
                dqs_timer_running <= 1'b0;
            else if (lim == 8'h00 && mpc_valid &&
                     mpc_opcode == tmr_pkg::MPC_STOP_DQS)
                dqs_timer_running <= 1'b0;
        end
    end

    assign max_act_mult = maxm_q;
    assign scale_ok = SCALE_SUPPORT;

    // Read side: one-cycle latency, write-only addresses read zero
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            mrr_data <= 8'h00;
            mrr_ack <= 1'b0;
        end
        else
        begin
            mrr_ack <= mrr_valid;
            if (mrr_valid)
            begin
                case (mrr_addr)
                    tmr_pkg::ADDR_TERM_OVR:
                        mrr_data <= ovr_q[setpoint_write_select];
                    // Multiplier field is write-only, so 7:6 read zero
                    tmr_pkg::ADDR_REFMGMT:
                        mrr_data <= {2'h0, INIT_THR_CODE,
                                     need_s};
                    tmr_pkg::ADDR_REPAIR:
                        mrr_data <= REPAIR_FLAGS;
                    tmr_pkg::ADDR_SCALE:
                        mrr_data <= scale_ok ? {6'h00, SCALE_LEVEL}
                                             : 8'h00;
                    default:
                        mrr_data <= 8'h00;
                endcase
            end
        end
    end

    // Stop must halt a free-running timer next cycle
    property p_stop_halts;
        @(posedge clk_sys) disable iff (srst)
        (dqs_timer_running && !dqs_timer_start && mpc_valid &&
         mpc_opcode == tmr_pkg::MPC_STOP_DQS && dqs_run_q == 8'h00)
        |=> !dqs_timer_running;
    endproperty
    a_stop_halts: assert property (p_stop_halts)
        else $error("timer not stopped by stop command");

    // Cycles since the last start; a write may move the code, so it clears
    logic [4:0] since_q;
    always_ff @(posedge clk_sys)
    begin
        if (srst || mrw_valid)
            since_q <= 5'h00;
        else if (dqs_timer_start)
            since_q <= 5'h01;
        else if (since_q != 5'h00 && since_q != 5'h1F)
            since_q <= 5'(since_q + 5'h01);
    end

    // Code 1 timer still runs at clock 16 after start, stopped after it
    property p_auto16;
        @(posedge clk_sys) disable iff (srst)
        (since_q == 5'h10 && dqs_run_q == 8'h01 && !dqs_timer_start)
        |-> dqs_timer_running ##1 !dqs_timer_running;
    endproperty
    a_auto16: assert property (p_auto16)
        else $error("auto stop not at 16 clocks");

    // Run time zero keeps the timer alive without a stop command
    property p_free_run;
        @(posedge clk_sys) disable iff (srst)
        (dqs_timer_running && dqs_run_q == 8'h00 &&
         !(mpc_valid && mpc_opcode == tmr_pkg::MPC_STOP_DQS))
        |=> dqs_timer_running;
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("free running timer stopped");

    // Upper-only select never terminates the lower byte of CA or CK
    property p_upper_only;
        @(posedge clk_sys) disable iff (srst)
        (bsel == tmr_pkg::BSEL_UPPER) |=> !ca_term_en[0] && !ck_term_en[0];
    endproperty
    a_upper_only: assert property (p_upper_only)
        else $error("lower byte terminated in upper mode");

    // Clear off bit with both bytes selected terminates CS on both
    property p_cs_both;
        @(posedge clk_sys) disable iff (srst)
        (ca_on && bsel == tmr_pkg::BSEL_BOTH &&
         !ovr_q[setpoint_op_select][tmr_pkg::CS_OFF_BIT] &&
         $stable(setpoint_op_select)) |=> (cs_term_en == 2'h3);
    endproperty
    a_cs_both: assert property (p_cs_both)
        else $error("CS not terminated on both bytes");

    // Disabled CA value gives no termination at all
    property p_ca_off;
        @(posedge clk_sys) disable iff (srst)
        !ca_on |=> (ca_term_en | cs_term_en | ck_term_en) == 2'h0;
    endproperty
    a_ca_off: assert property (p_ca_off)
        else $error("termination with CA value disabled");

    // Read of the override returns the write-selected copy
    property p_rd_copy;
        @(posedge clk_sys) disable iff (srst)
        (mrr_valid && mrr_addr == tmr_pkg::ADDR_TERM_OVR && !mrw_valid)
        |=> mrr_ack && mrr_data == $past(ovr_q[setpoint_write_select]);
    endproperty
    a_rd_copy: assert property (p_rd_copy)
        else $error("override read from wrong copy");

    // Repair flags read back unchanged
    property p_repair;
        @(posedge clk_sys) disable iff (srst)
        (mrr_valid && mrr_addr == tmr_pkg::ADDR_REPAIR)
        |=> mrr_data == REPAIR_FLAGS;
    endproperty
    a_repair: assert property (p_repair)
        else $error("repair flags misread");
endmodule

// ---- rtl/tmr_sync2.sv ----
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ns
module tmr_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic [WIDTH-1:0] d, // Asynchronous input
    output logic [WIDTH-1:0] q // Synchronised output
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            meta_q <= '0;
            q <= '0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ---- test/termination_and_timer_mode_regs_tb.sv ----
// Self-checking testbench for the termination and timer mode registers
`timescale 1ns/1ns
module termination_and_timer_mode_regs_tb;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic wsel = 1'b0, osel = 1'b0, pad = 1'b0, need = 1'b0, start = 1'b0;
    logic [2:0] ca_val = 3'h4;
    logic mrw_valid, mrr_valid, mrr_ack, mpc_valid, running;
    logic [5:0] mrw_addr, mrr_addr;
    logic [7:0] mrw_data, mrr_data, rv;
    logic [6:0] mpc_opcode;
    logic [1:0] ca_t, cs_t, ck_t;
    logic [2:0] maxm;
    int n_mismatch = 0, checked = 0;
    // Clock at 125 MHz
    always #4 clk_sys = ~clk_sys;
    tmr_regs #(.REPAIR_FLAGS(8'hA5), .SCALE_LEVEL(2'h2),
        .INIT_THR_CODE(5'h1F), .SCALE_SUPPORT(1'b1)) uut (
        .clk_sys(clk_sys), .srst(srst), .mrw_valid(mrw_valid),
        .mrw_addr(mrw_addr), .mrw_data(mrw_data), .mrr_valid(mrr_valid),
        .mrr_addr(mrr_addr), .mrr_data(mrr_data), .mrr_ack(mrr_ack),
        .setpoint_write_select(wsel), .setpoint_op_select(osel),
        .ca_termination_value(ca_val), .termination_strap_pad(pad),
        .refresh_need(need), .mpc_valid(mpc_valid), .mpc_opcode(mpc_opcode),
        .dqs_timer_start(start), .dqs_timer_running(running),
        .ca_term_en(ca_t), .cs_term_en(cs_t), .ck_term_en(ck_t),
        .max_act_mult(maxm));
    tmr_ctrl_model ctrl (.clk_sys(clk_sys), .mrr_data(mrr_data),
        .mrr_ack(mrr_ack), .mrw_valid(mrw_valid), .mrw_addr(mrw_addr),
        .mrw_data(mrw_data), .mrr_valid(mrr_valid), .mrr_addr(mrr_addr),
        .mpc_valid(mpc_valid), .mpc_opcode(mpc_opcode));
    // Compare and count
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Let a write reach the registered termination outputs
    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic pulse_start();
        @(posedge clk_sys);
        #1;
        start = 1'b1;
        @(posedge clk_sys);
        #1;
        start = 1'b0;
    endtask
    // Every byte select and override combination, strap pad toggling
    task automatic t_term();
        logic [1:0] m;
        for (int b = 0; b < 4; b++)
            for (int k = 0; k < 8; k++)
            begin
                pad = k[0];
                ctrl.wr(tmr_pkg::ADDR_TERM_OVR, {2'(b), 3'(k), 3'h0});
                settle();
                m = b == 0 ? 2'h3 : b == 1 ? 2'h2 : b == 2 ? 2'h1 : 2'h0;
                chk("ca", {6'h00, ca_t}, {6'h00, k[2] ? 2'h0 : m});
                chk("cs", {6'h00, cs_t}, {6'h00, k[1] ? 2'h0 : m});
                chk("ck", {6'h00, ck_t}, {6'h00, k[0] ? 2'h0 : m});
            end
        ca_val = 3'h0;
        ctrl.wr(tmr_pkg::ADDR_TERM_OVR, 8'h00);
        settle();
        chk("ca_off", {6'h00, ca_t}, 8'h00);
        ca_val = 3'h4;
    endtask
    // Write the inactive copy, then swap the active one
    task automatic t_copies();
        wsel = 1'b1;
        ctrl.wr(tmr_pkg::ADDR_TERM_OVR, 8'h38);
        settle();
        chk("inactive", {2'h0, ca_t, cs_t, ck_t}, 8'h3F);
        osel = 1'b1;
        settle();
        chk("active1", {2'h0, ca_t, cs_t, ck_t}, 8'h00);
        wsel = 1'b0;
        ctrl.wr(tmr_pkg::ADDR_TERM_OVR, 8'h40);
        osel = 1'b0;
        settle();
        chk("active0", {2'h0, ca_t, cs_t, ck_t}, 8'h2A);
        ctrl.rd(tmr_pkg::ADDR_TERM_OVR, rv);
        chk("rd_copy0", rv, 8'h40);
        wsel = 1'b1;
        ctrl.rd(tmr_pkg::ADDR_TERM_OVR, rv);
        chk("rd_copy1", rv, 8'h38);
        wsel = 1'b0;
    endtask
    // Default run time free-runs until the stop opcode alone
    task automatic t_free_run();
        pulse_start();
        repeat (100) @(posedge clk_sys);
        #1;
        chk("free_run", {7'h00, running}, 8'h01);
        ctrl.multipurpose_command(7'h4C);
        settle();
        chk("other_op", {7'h00, running}, 8'h01);
        ctrl.multipurpose_command(tmr_pkg::MPC_STOP_DQS);
        settle();
        chk("stopped", {7'h00, running}, 8'h00);
    endtask
    // Auto-stop codes, clocks of running counted
    task automatic t_auto_stop();
        int n;
        for (int c = 1; c <= 4; c++)
        begin
            ctrl.wr(tmr_pkg::ADDR_DQS_RUN, 8'(c));
            pulse_start();
            n = 0;
            // Sample settled values, starting with the one after the start
            repeat (80)
            begin
                n += int'(running === 1'b1);
                @(posedge clk_sys);
                #1;
            end
            chk("run_clks", 8'(n), 8'(16 * c));
        end
        // Codes above 4 run free; the stop opcode needs code zero first
        ctrl.wr(tmr_pkg::ADDR_DQS_RUN, 8'h05);
        pulse_start();
        repeat (80) @(posedge clk_sys);
        #1;
        chk("code5_run", {7'h00, running}, 8'h01);
        ctrl.wr(tmr_pkg::ADDR_DQS_RUN, 8'h00);
        ctrl.multipurpose_command(tmr_pkg::MPC_STOP_DQS);
        settle();
        chk("code0_stop", {7'h00, running}, 8'h00);
    endtask
    // Read-only info registers, refresh fields and unmapped places
    task automatic t_info();
        ctrl.rd(tmr_pkg::ADDR_REPAIR, rv);
        chk("repair", rv, 8'hA5);
        ctrl.wr(tmr_pkg::ADDR_REPAIR, 8'h00);
        ctrl.rd(tmr_pkg::ADDR_REPAIR, rv);
        chk("repair_ro", rv, 8'hA5);
        ctrl.rd(tmr_pkg::ADDR_SCALE, rv);
        chk("scale", rv, 8'h02);
        ctrl.rd(6'h3F, rv);
        chk("unmapped", rv, 8'h00);
        for (int i = 1; i >= 0; i--)
        begin
            need = 1'(i);
            repeat (4) @(posedge clk_sys);
            ctrl.rd(tmr_pkg::ADDR_REFMGMT, rv);
            chk("rfm_need", {7'h00, rv[0]}, 8'(i));
            chk("rfm_thr", rv & 8'hFE, 8'h3E);
        end
        ctrl.wr(tmr_pkg::ADDR_REFMGMT, 8'h70);
        settle();
        chk("max_mult", {5'h00, maxm}, 8'h07);
        ctrl.wr(tmr_pkg::ADDR_REFMGMT, 8'h30);
        settle();
        chk("max_mult", {5'h00, maxm}, 8'h03);
    endtask
    task automatic summarize();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        chk("rst_ca", {6'h00, ca_t}, 8'h00);
        t_free_run();
        t_term();
        t_copies();
        t_auto_stop();
        t_info();
        summarize();
    end
    // Hang guard, well beyond the roughly 760 clocks needed
    initial
    begin
        #100000;
        n_mismatch++;
        summarize();
    end
endmodule

// ---- test/tmr_ctrl_model.sv ----
// Memory controller model issuing register and multipurpose commands
`timescale 1ns/1ns
module tmr_ctrl_model (
    input wire logic clk_sys, // System clock
    input wire logic [7:0] mrr_data, // Read data
    input wire logic mrr_ack, // Read data valid
    output logic mrw_valid, // Write strobe
    output logic [5:0] mrw_addr, // Write address
    output logic [7:0] mrw_data, // Write operand
    output logic mrr_valid, // Read strobe
    output logic [5:0] mrr_addr, // Read address
    output logic mpc_valid, // Command strobe
    output logic [6:0] mpc_opcode // Command opcode
);
    logic [7:0] run_code = 8'h00; // Run time last written
    // Bus idle at power up
    initial
    begin
        mrw_valid = 1'b0;
        mrr_valid = 1'b0;
        mpc_valid = 1'b0;
        {mrw_addr, mrw_data, mrr_addr, mpc_opcode} = '0;
    end
    // Released lines show the inverse so stale values cannot pass
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        {mrw_valid, mrw_addr, mrw_data} = {1'b1, a, d};
        if (a == tmr_pkg::ADDR_DQS_RUN)
            run_code = d;
        @(posedge clk_sys);
        #1;
        {mrw_valid, mrw_addr, mrw_data} = {1'b0, ~a, ~d};
    endtask
    // Read answer is a one-cycle pulse; give up after a few edges
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        d = 'x;
        @(posedge clk_sys);
        #1;
        {mrr_valid, mrr_addr} = {1'b1, a};
        @(posedge clk_sys);
        #1;
        {mrr_valid, mrr_addr} = {1'b0, ~a};
        for (int i = 0; i < 4; i++)
        begin
            if (mrr_ack === 1'b1)
            begin
                d = mrr_data;
                break;
            end
            @(posedge clk_sys);
            #1;
        end
    endtask
    // Stop opcode is withheld while any nonzero run time is set
    task automatic multipurpose_command(input logic [6:0] op);
        if (op == tmr_pkg::MPC_STOP_DQS && run_code != 8'h00)
            return;
        @(posedge clk_sys);
        #1;
        {mpc_valid, mpc_opcode} = {1'b1, op};
        @(posedge clk_sys);
        #1;
        {mpc_valid, mpc_opcode} = {1'b0, ~op};
    endtask
endmodule
